// ### nine_bit_uart.v
// Nine-bit asynchronous serial port with address recognition, AXI4-Lite.
//
// Notes on behaviour
// - After a buffer write, transmission starts only at the next bit rollover.
// - One bit per rollover; transmit flag rises on the eleventh rollover.
// - Receive only when enabled; sample line sixteen times per bit.
// - A detected falling edge restarts the receive bit counter at once.
// - Each bit is the majority of slices seven, eight and nine.
// - A high voted start bit aborts; otherwise shift remaining bits.
// - Load only if flag clear and multiproc off or ninth bit one.
// - Edge search resumes at the middle of the stop bit.
// - Mode three equals mode two except baud comes from timer overflow.
// - A stop bit that is not high sets the framing-error flag.
// - Mode bit and error flag share a position; selector picks one.
// - Error flag set only by hardware, cleared only by software write.
// - With multiproc on, address frames need given or broadcast match.
// - With multiproc off, every complete frame raises the receive flag.
// - Given address compares only bits whose mask bit is one.
// - Broadcast address is address OR mask; zeros are don't-care.
// - Address and mask reset to zero, so every address matches.
// - Frame is start low, eight data LSB first, ninth bit, stop high.
// - Oscillator mode baud is clock/32 or clock/64 per doubling bit.
// - Buffer writes go to transmitter, reads come from receive holder.
`timescale 1ns/1ps
`include "uart9_defs.vh"

module nine_bit_uart (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire timer_ovf_i,
  input wire rxd_i,
  output reg txd_o
);

  // Receive states, one-hot.
  localparam RX_SEARCH = 2'b01;
  localparam RX_FRAME = 2'b10;

  // Software-visible storage.
  reg [7:0] serial_control;
  reg frame_error_flag;
  reg [7:0] power_control;
  reg [7:0] station_address;
  reg [7:0] station_address_mask;
  reg [7:0] rx_holding;
  reg [7:0] tx_data;

  // Bus write side: captured address and data, then a one-cycle strobe.
  reg [11:0] aw_addr;
  reg aw_got;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_got;
  reg wr_stb;
  reg [7:0] wr_idx;
  reg [7:0] wr_val;

  // Transmit and receive machinery.
  reg tx_start;
  reg tx_pending;
  reg tx_busy;
  reg [3:0] tx_slice;
  reg [3:0] tx_count;
  reg [9:0] tx_shift;
  reg tx_done;
  reg rx_s1, rx_s2, rx_s3;
  reg rx_level;
  reg rx_prev;
  reg [1:0] rx_state;
  reg [3:0] rx_slice;
  reg [3:0] rx_index;
  reg [2:0] votes;
  reg [8:0] rx_shift;
  reg rx_load;
  reg rx_ninth_new;
  reg [7:0] rx_byte_new;
  reg fe_set;

  wire tick16;
  wire mode_on;
  wire tx_rollover;
  wire voted;
  wire [7:0] broadcast;
  wire addr_ok;

  // True when every bit that care marks as one agrees between a and b.
  function masked_eq;
    input [7:0] a;
    input [7:0] b;
    input [7:0] care;
    begin
      masked_eq = ((a ^ b) & care) == 8'h00;
    end
  endfunction

  // Byte address to register index; misaligned addresses map nowhere.
  function [8:0] decode;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0)
        decode = 9'h100;
      else
        decode = {1'b0, addr[9:2]};
    end
  endfunction

  function mapped;
    input [8:0] idx;
    begin
      mapped = (idx == {1'b0, `IDX_SERIAL_CONTROL}) ||
               (idx == {1'b0, `IDX_SERIAL_BUFFER}) ||
               (idx == {1'b0, `IDX_POWER_CONTROL}) ||
               (idx == {1'b0, `IDX_STATION_ADDRESS}) ||
               (idx == {1'b0, `IDX_STATION_ADDRESS_MASK});
    end
  endfunction

  // Only modes two and three are built; the high mode bit enables the port.
  assign mode_on = serial_control[`SC_MODE_HIGH];

  // Mode three takes the timer overflow, mode two the clock.
  uart9_baud_tick u_tick (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .use_timer_i(serial_control[`SC_MODE_LOW]),
    .baud_double_i(power_control[`PC_BAUD_DOUBLE]),
    .timer_ovf_i(timer_ovf_i),
    .tick16_o(tick16)
  );

  // AXI4-Lite write channel: address and data accepted in either order.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      wr_stb <= 1'b0;
      wr_idx <= 8'h00;
      wr_val <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (mapped(decode(aw_addr))) begin
          s_axi_bresp <= `RESP_OKAY;
          // Only the low byte lane carries register bits.
          wr_stb <= w_strb[0];
          wr_idx <= aw_addr[9:2];
          wr_val <= w_data[7:0];
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel; reads have no side effects.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(decode(s_axi_araddr)) ? `RESP_OKAY :
                       `RESP_SLVERR;
        case (decode(s_axi_araddr))
          {1'b0, `IDX_SERIAL_CONTROL}:
            // The top bit shows the error flag or the mode bit.
            s_axi_rdata <= {24'h000000,
              power_control[`PC_ERR_SELECT] ? frame_error_flag :
              serial_control[`SC_MODE_HIGH], serial_control[6:0]};
          {1'b0, `IDX_SERIAL_BUFFER}:
            s_axi_rdata <= {24'h000000, rx_holding};
          {1'b0, `IDX_POWER_CONTROL}:
            s_axi_rdata <= {24'h000000, power_control};
          {1'b0, `IDX_STATION_ADDRESS}:
            s_axi_rdata <= {24'h000000, station_address};
          {1'b0, `IDX_STATION_ADDRESS_MASK}:
            s_axi_rdata <= {24'h000000, station_address_mask};
          default:
            s_axi_rdata <= 32'h00000000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Register file and flags. Hardware set beats a software clear in the
  // same cycle so that no event is lost.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_control <= `RST_SERIAL_CONTROL;
      frame_error_flag <= 1'b0;
      power_control <= `RST_POWER_CONTROL;
      station_address <= `RST_STATION_ADDRESS;
      station_address_mask <= `RST_STATION_ADDRESS_MASK;
      rx_holding <= 8'h00;
      tx_data <= 8'h00;
      tx_start <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      if (wr_stb) begin
        case (wr_idx)
          `IDX_SERIAL_CONTROL: begin
            serial_control[6:0] <= wr_val[6:0];
            // Selector steers the shared bit; software may only clear
            // the error flag.
            if (power_control[`PC_ERR_SELECT]) begin
              if (!wr_val[7])
                frame_error_flag <= 1'b0;
            end else begin
              serial_control[7] <= wr_val[7];
            end
          end
          `IDX_SERIAL_BUFFER: begin
            tx_data <= wr_val;
            tx_start <= mode_on;
          end
          `IDX_POWER_CONTROL: power_control <= wr_val;
          `IDX_STATION_ADDRESS: station_address <= wr_val;
          `IDX_STATION_ADDRESS_MASK: station_address_mask <= wr_val;
          default: ;
        endcase
      end
      if (tx_done)
        serial_control[`SC_TX_FLAG] <= 1'b1;
      if (rx_load) begin
        // Store ninth bit, byte and flag together.
        serial_control[`SC_RX_NINTH] <= rx_ninth_new;
        serial_control[`SC_RX_FLAG] <= 1'b1;
        rx_holding <= rx_byte_new;
      end
      if (fe_set)
        frame_error_flag <= 1'b1;
    end
  end

  // Transmit rollover: every sixteenth tick of a free-running counter.
  assign tx_rollover = tick16 && (tx_slice == 4'hF);

  // Transmitter. The write only arms it; the first bit waits for the
  // rollover so that bit edges stay on the divided counter.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_slice <= 4'h0;
      tx_pending <= 1'b0;
      tx_busy <= 1'b0;
      tx_count <= 4'h0;
      tx_shift <= 10'h3FF;
      tx_done <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      tx_done <= 1'b0;
      if (tick16)
        tx_slice <= tx_slice + 4'h1;
      if (tx_start) begin
        // Data LSB first, then the ninth bit, then a high stop.
        tx_shift <= {1'b1, serial_control[`SC_TX_NINTH], tx_data};
        tx_pending <= 1'b1;
        tx_busy <= 1'b0;
        tx_count <= 4'h0;
        txd_o <= 1'b1;
      end else if (tx_rollover && tx_pending) begin
        tx_pending <= 1'b0;
        tx_busy <= 1'b1;
        tx_count <= 4'h1;
        txd_o <= 1'b0;
      end else if (tx_rollover && tx_busy) begin
        // One bit per rollover; stop goes out on the eleventh.
        txd_o <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_count <= tx_count + 4'h1;
        if (tx_count + 4'h1 == `TX_LAST_ROLLOVER) begin
          tx_busy <= 1'b0;
          tx_done <= 1'b1;
        end
      end
    end
  end

  // Receive line: three flops, a change counts once the last two agree.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_level <= 1'b1;
    end else begin
      rx_s1 <= rxd_i;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3)
        rx_level <= rx_s3;
    end
  end

  // Majority of the three slice samples.
  assign voted = (votes[0] & votes[1]) | (votes[0] & votes[2]) |
                 (votes[1] & votes[2]);

  // Address recognition: given address under the mask, broadcast as the
  // OR of address and mask with zero bits ignored.
  assign broadcast = station_address | station_address_mask;
  // The received byte sits below the ninth bit in the shift register.
  assign addr_ok =
    masked_eq(rx_shift[7:0], station_address, station_address_mask) ||
    masked_eq(rx_shift[7:0], broadcast, broadcast);

  // Receiver. Only the sixteen-times tick moves it, and only while the
  // port is enabled; dropping the enable abandons a frame.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state <= RX_SEARCH;
      rx_prev <= 1'b1;
      rx_slice <= 4'h0;
      rx_index <= 4'h0;
      votes <= 3'h7;
      rx_shift <= 9'h000;
      rx_load <= 1'b0;
      rx_ninth_new <= 1'b0;
      rx_byte_new <= 8'h00;
      fe_set <= 1'b0;
    end else begin
      rx_load <= 1'b0;
      fe_set <= 1'b0;
      if (!mode_on || !serial_control[`SC_RX_ENABLE]) begin
        rx_state <= RX_SEARCH;
        rx_prev <= rx_level;
      end else if (tick16) begin
        case (rx_state)
          RX_SEARCH: begin
            rx_prev <= rx_level;
            if (rx_prev && !rx_level) begin
              // Restart the bit counter on the edge itself.
              rx_slice <= 4'h1;
              rx_index <= 4'h0;
              rx_state <= RX_FRAME;
            end
          end
          RX_FRAME: begin
            rx_slice <= rx_slice + 4'h1;
            if (rx_slice == `SLICE_VOTE_A)
              votes[0] <= rx_level;
            if (rx_slice == `SLICE_VOTE_B)
              votes[1] <= rx_level;
            if (rx_slice == `SLICE_VOTE_C) begin
              votes[2] <= rx_level;
            end
            if (rx_slice == 4'hF)
              rx_index <= rx_index + 4'h1;
            // Decide the bit the slice after the third sample.
            if (rx_slice == `SLICE_VOTE_C + 4'h1) begin
              if (rx_index == 4'h0) begin
                if (voted) begin
                  rx_state <= RX_SEARCH;
                  rx_prev <= rx_level;
                end
              end else if (rx_index != `RX_STOP_INDEX) begin
                rx_shift <= {voted, rx_shift[8:1]};
              end else begin
                // Middle of the stop bit: finish and search again.
                rx_state <= RX_SEARCH;
                rx_prev <= rx_level;
                fe_set <= !voted;
                rx_ninth_new <= rx_shift[8];
                rx_byte_new <= rx_shift[7:0];
                // With the receive flag clear, multiproc off takes every frame;
                // on, only matched address frames.
                rx_load <= !serial_control[`SC_RX_FLAG] &&
                  (!serial_control[`SC_MULTIPROC] ||
                   (rx_shift[8] && addr_ok));
              end
            end
          end
          default: rx_state <= RX_SEARCH;
        endcase
      end
    end
  end

endmodule

// ### nine_bit_uart_tb.sv
// Self-checking bench: bus access, transmit, receive and address match.
`timescale 1ns/1ps
`include "uart9_defs.vh"
module nine_bit_uart_tb;
  reg mclk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready, tmr;
  reg [11:0] awaddr, araddr;
  reg [31:0] wdata;
  reg [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, txd, rxd;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [31:0] v;
  reg [1:0] rs;
  reg [17:0] tbl [0:6];
  integer miscompares, total_checks, k, n;
  time wend;
  nine_bit_uart dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_ovf_i(tmr), .rxd_i(rxd), .txd_o(txd));
  serial_peer #(.BIT_CLKS(32)) peer_u (.mclk_i(mclk_i), .line_i(txd),
    .line_o(rxd));
  // Clock, plus a timer overflow on every other cycle for mode three.
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) tmr <= ~tmr;
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // One clock of a bounded wait; a wait that runs out ends the run.
  task tick(inout integer cnt);
    begin
      @(posedge mclk_i);
      cnt = cnt + 1;
      if (cnt > 2000) begin
        miscompares = miscompares + 1;
        $display("MISMATCH at %0t: wait ran out", $time);
        end_sim;
      end
    end
  endtask
  // Address and data are offered together and dropped as each is taken.
  task wr(input [7:0] idx, input [7:0] d, output [1:0] r);
    integer c;
    begin
      c = 0;
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        tick(c);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge mclk_i); // Keeps bready to one change per time step.
    end
  endtask
  task rd(input [7:0] idx, output [31:0] d, output [1:0] r);
    integer c;
    begin
      c = 0;
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        tick(c);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge mclk_i); // Keeps rready to one change per time step.
    end
  endtask
  task rchk(input [7:0] idx, input [7:0] m, input [7:0] exp);
    begin
      rd(idx, v, rs);
      chk({30'h0, rs}, {30'h0, `RESP_OKAY});
      chk(v & {24'h0, m}, {24'h0, exp});
    end
  endtask
  // Main sequence; after the time-zero setup, inputs change only by non-blocking assignment.
  initial begin
    rst_n_i = 1'b0; tmr = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = 12'h0;
    araddr = 12'h0; wdata = 32'h0; wstrb = 4'hF;
    miscompares = 0;
    total_checks = 0;
    tbl[0] = {8'h90, 8'h3C, 1'b0, 1'b1};
    tbl[1] = {8'h90, 8'h5A, 1'b1, 1'b1};
    tbl[2] = {8'hB0, 8'hA0, 1'b1, 1'b1};
    tbl[3] = {8'hB0, 8'hA2, 1'b1, 1'b0};
    tbl[4] = {8'hB0, 8'hFE, 1'b1, 1'b1};
    tbl[5] = {8'hB0, 8'hA0, 1'b0, 1'b0};
    tbl[6] = {8'hD0, 8'h69, 1'b0, 1'b1};
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rchk(`IDX_STATION_ADDRESS, 8'hFF, 8'h00);
    rchk(`IDX_STATION_ADDRESS_MASK, 8'hFF, 8'h00);
    rd(8'h10, v, rs);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    wr(8'h10, 8'h55, rs);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    $display("test reset_values done");
    wr(`IDX_POWER_CONTROL, 8'h80, rs);
    chk({30'h0, rs}, {30'h0, `RESP_OKAY});
    wr(`IDX_SERIAL_CONTROL, 8'h98, rs);
    wr(`IDX_SERIAL_BUFFER, 8'hA5, rs);
    wend = $time;
    n = 0;
    while (peer_u.heard_count == 0) tick(n);
    chk({31'h0, peer_u.fall_time - wend <= 400}, 32'h1);
    chk({21'h0, peer_u.heard_start, peer_u.heard}, 32'h3A5);
    rchk(`IDX_SERIAL_CONTROL, 8'h02, 8'h02);
    $display("test transmit done");
    wr(`IDX_STATION_ADDRESS, 8'hA4, rs);
    wr(`IDX_STATION_ADDRESS_MASK, 8'hFA, rs);
    rchk(`IDX_STATION_ADDRESS_MASK, 8'hFF, 8'hFA);
    // Each entry: control, byte, ninth bit, whether it must load.
    for (k = 0; k < 7; k = k + 1) begin
      wr(`IDX_SERIAL_CONTROL, tbl[k][17:10], rs);
      peer_u.send(tbl[k][9:2], tbl[k][1], 1'b1);
      rchk(`IDX_SERIAL_CONTROL, {5'h0, tbl[k][0], 2'h1},
        {5'h0, tbl[k][1] & tbl[k][0], 1'b0, tbl[k][0]});
      if (tbl[k][0])
        rchk(`IDX_SERIAL_BUFFER, 8'hFF, tbl[k][9:2]);
    end
    $display("test receive_match done");
    wr(`IDX_SERIAL_CONTROL, 8'h90, rs);
    peer_u.pulse(4);
    rchk(`IDX_SERIAL_CONTROL, 8'h01, 8'h00);
    peer_u.send(8'h11, 1'b0, 1'b0);
    peer_u.send(8'h22, 1'b0, 1'b1);
    rchk(`IDX_SERIAL_BUFFER, 8'hFF, 8'h11);
    wr(`IDX_POWER_CONTROL, 8'hC0, rs);
    rchk(`IDX_SERIAL_CONTROL, 8'h80, 8'h80);
    wr(`IDX_SERIAL_CONTROL, 8'h10, rs);
    rchk(`IDX_SERIAL_CONTROL, 8'h80, 8'h00);
    wr(`IDX_POWER_CONTROL, 8'h80, rs);
    rchk(`IDX_SERIAL_CONTROL, 8'h80, 8'h80);
    $display("test frame_error done");
    // Undoubled clock rate: ten low bits of 64 clocks each.
    wr(`IDX_POWER_CONTROL, 8'h00, rs);
    wr(`IDX_SERIAL_BUFFER, 8'h00, rs);
    n = 0;
    while (txd) tick(n);
    wend = $time;
    while (!txd) tick(n);
    chk({31'h0, $time - wend == 64'h1900}, 32'h1);
    $display("test slow_baud done");
    end_sim;
  end
endmodule

// ### serial_peer.sv
// Far station model: sends frames on the line and decodes what it hears.
`timescale 1ns/1ps
module serial_peer #(
  parameter BIT_CLKS = 32
) (
  input wire mclk_i,
  input wire line_i,
  output reg line_o
);
  reg [9:0] heard;
  reg heard_start;
  integer heard_count;
  integer i;
  time fall_time;
  // The line idles high; nothing else drives it between frames.
  initial begin
    line_o = 1'b1;
    heard_count = 0;
  end
  // Start low, data LSB first, ninth bit marks addresses, then stop.
  task send(input [7:0] d, input n9, input stop);
    reg [10:0] f;
    integer k;
    begin
      f = {stop, n9, d, 1'b0};
      for (k = 0; k < 11; k = k + 1) begin
        @(posedge mclk_i);
        line_o <= f[k];
        repeat (BIT_CLKS - 1) @(posedge mclk_i);
      end
      @(posedge mclk_i);
      line_o <= 1'b1;
      repeat (BIT_CLKS) @(posedge mclk_i);
    end
  endtask
  // A short low pulse that a voting receiver must not take as a start.
  task pulse(input integer len);
    begin
      @(posedge mclk_i);
      line_o <= 1'b0;
      repeat (len) @(posedge mclk_i);
      line_o <= 1'b1;
      repeat (12 * BIT_CLKS) @(posedge mclk_i);
    end
  endtask
  // Each bit is sampled in its middle, half a bit after the fall.
  always begin
    @(negedge line_i);
    fall_time = $time;
    repeat (BIT_CLKS / 2) @(posedge mclk_i);
    heard_start = line_i;
    for (i = 0; i < 10; i = i + 1) begin
      repeat (BIT_CLKS) @(posedge mclk_i);
      heard[i] = line_i;
    end
    heard_count = heard_count + 1;
  end
endmodule

// ### uart9_baud_tick.v
// Sixteen-times-baud tick generator for the oscillator and timer sources.
`timescale 1ns/1ps
`include "uart9_defs.vh"

module uart9_baud_tick (
  input wire mclk_i,
  input wire rst_n_i,
  input wire use_timer_i,
  input wire baud_double_i,
  input wire timer_ovf_i,
  output reg tick16_o
);

  reg [2:0] count;
  wire [2:0] divisor;
  wire step;

  // The timer source advances only on its overflow pulse.
  assign step = use_timer_i ? timer_ovf_i : 1'b1;
  assign divisor = use_timer_i ?
    (baud_double_i ? `TMR_DIV_FAST : `TMR_DIV_SLOW) :
    (baud_double_i ? `OSC_DIV_FAST : `OSC_DIV_SLOW);

  // Prescaler; a one-cycle tick each time it wraps.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 3'h0;
      tick16_o <= 1'b0;
    end else begin
      tick16_o <= 1'b0;
      if (step) begin
        if (count + 3'h1 >= divisor) begin
          count <= 3'h0;
          tick16_o <= 1'b1;
        end else begin
          count <= count + 3'h1;
        end
      end
    end
  end

endmodule

// ### uart9_chk_asserts.sv
// Checker for bus handshakes and serial line timing of the port.
`timescale 1ns/1ps
module uart9_chk (
  input wire mclk_i,
  input wire rst_n_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire txd_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Bus answers come at fixed distances from the handshake.
  a_write_lat: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // A second request is refused while an answer is pending.
  a_aw_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer not released");
  a_r_release: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
  a_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  // The line is high on leaving reset, and no low bit is shorter than eight clocks.
  a_tx_idle: assert property (
    $rose(rst_n_i) |-> txd_o && !s_axi_bvalid && !s_axi_rvalid)
    else $error("port not idle after reset");
  a_bit_width: assert property (
    $fell(txd_o) |-> !txd_o [*8]) else $error("low bit too short");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_frame: cover property ($fell(txd_o));
endmodule
bind nine_bit_uart uart9_chk chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .txd_o(txd_o));

// ### uart9_defs.vh
// Constants for the nine-bit serial port: register map, bit fields, timing.
`ifndef UART9_DEFS_VH
`define UART9_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_SERIAL_CONTROL 8'hA0
`define IDX_SERIAL_BUFFER 8'hA1
`define IDX_POWER_CONTROL 8'hA2
`define IDX_STATION_ADDRESS 8'hA9
`define IDX_STATION_ADDRESS_MASK 8'hB9

// Field positions in serial_control.
`define SC_MODE_HIGH 7
`define SC_MODE_LOW 6
`define SC_MULTIPROC 5
`define SC_RX_ENABLE 4
`define SC_TX_NINTH 3
`define SC_RX_NINTH 2
`define SC_TX_FLAG 1
`define SC_RX_FLAG 0

// Field positions in power_control.
`define PC_BAUD_DOUBLE 7
`define PC_ERR_SELECT 6

// Reset values.
`define RST_SERIAL_CONTROL 8'h00
`define RST_POWER_CONTROL 8'h00
`define RST_STATION_ADDRESS 8'h00
`define RST_STATION_ADDRESS_MASK 8'h00

// Clocks per sixteenth of a bit in the oscillator-derived mode.
// Baud is clock/64 normally (16 x 4) and clock/32 when doubled (16 x 2).
`define OSC_DIV_SLOW 3'h4
`define OSC_DIV_FAST 3'h2
// Timer overflows per sixteenth of a bit in the timer-derived mode.
`define TMR_DIV_SLOW 3'h2
`define TMR_DIV_FAST 3'h1

// Frame layout, counted in bit times.
`define TX_LAST_ROLLOVER 4'hB
`define RX_STOP_INDEX 4'hA
// Slice numbers (zero based) of the three voting samples.
`define SLICE_VOTE_A 4'h7
`define SLICE_VOTE_B 4'h8
`define SLICE_VOTE_C 4'h9

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif
